/* File: verilog/bab_exec.sv */
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module bab_exec #(
  parameter logic [6:0] TIMER_ZERO_COUNT_ADDR = bab_pkg::TIMER_ZERO_COUNT_ADDR_DEF,
  parameter logic [6:0] PORT_A_ADDR           = bab_pkg::PORT_A_ADDR_DEF,
  parameter logic [6:0] PORT_C_ADDR           = bab_pkg::PORT_C_ADDR_DEF
) (
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [bab_pkg::APB_AW-1:0] paddr_in,
  input  wire logic [31:0]                pwdata_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  input  wire logic                       op_valid_in,
  input  wire bab_pkg::bab_op_t           op_code_in,
  input  wire logic [6:0]                 op_addr_in,
  input  wire logic [7:0]                 op_literal_in,
  input  wire logic [2:0]                 op_bit_in,
  input  wire logic                       op_dest_in,
  output logic                            op_ready_out,
  output logic                            skip_out,
  output logic                            done_out,
  output logic      [6:0]                 file_addr_out,
  input  wire logic [7:0]                 file_rd_data_in,
  output logic                            file_we_out,
  output logic      [7:0]                 file_wdata_out,
  input  wire logic [7:0]                 pin_a_in,
  input  wire logic [7:0]                 pin_c_in,
  input  wire logic                       prescaler_to_timer_in,
  output logic                            prescaler_clear_out,
  output logic      [7:0]                 acc_out,
  output logic                            carry_out,
  output logic                            digit_carry_flag_out,
  output logic                            zero_out
);
  import bab_pkg::*;

  typedef struct packed {
    bab_phase_t  phase;
    bab_op_t     op;
    logic [6:0]  addr;
    logic [7:0]  lit;
    logic [2:0]  bsel;
    logic        dest;
    logic [7:0]  opnd;
    logic [7:0]  acc;
    logic        carry;
    logic        digit_carry;
    logic        zero;
    logic        enable;
    logic        skip_pend;
    logic        skip_now;
    logic [7:0]  pin_a_s1;
    logic [7:0]  pin_a_s2;
    logic [7:0]  pin_c_s1;
    logic [7:0]  pin_c_s2;
    logic        file_we;
    logic [7:0]  file_wdata;
    logic        psc_clr;
    logic        done;
    logic [31:0] prdata;
    logic        pslverr;
  } bab_state_t;

  bab_state_t q;
  bab_state_t d;

  logic [7:0] alu_opnd;
  logic [7:0] alu_res;
  logic       alu_carry;
  logic       alu_digit;
  logic       alu_zero;
  logic       alu_bit;
  logic       lit_op;
  logic       reg_op;
  logic       add_op;
  logic       and_op;
  logic       test_op;
  logic       writes_file;
  logic       accept;
  logic       apb_setup;
  logic       apb_wr;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign lit_op  = (q.op == OP_ADD_LITERAL) || (q.op == OP_AND_LITERAL);
  assign reg_op  = (q.op == OP_ADD_REGISTER) || (q.op == OP_AND_REGISTER);
  assign add_op  = (q.op == OP_ADD_LITERAL) || (q.op == OP_ADD_REGISTER);
  assign and_op  = (q.op == OP_AND_LITERAL) || (q.op == OP_AND_REGISTER);
  assign test_op = (q.op == OP_SKIP_IF_ONE) || (q.op == OP_SKIP_IF_ZERO);
  assign alu_opnd = lit_op ? q.lit : q.opnd;
  // Result goes to the file for bit ops or register ops with destination one
  assign writes_file = (reg_op && q.dest) ||
                       (q.op == OP_BIT_CLEAR) || (q.op == OP_BIT_SET);

  assign op_ready_out = (q.phase == PH_FETCH) && q.enable;
  assign accept       = op_ready_out && op_valid_in;
  assign apb_setup    = psel_in && !penable_in;
  assign apb_wr       = psel_in && penable_in && pwrite_in;

  bab_alu u_alu (
    .op_in           (q.op),
    .acc_in          (q.acc),
    .opnd_in         (alu_opnd),
    .bsel_in         (q.bsel),
    .res_out         (alu_res),
    .carry_out       (alu_carry),
    .digit_carry_out (alu_digit),
    .zero_out        (alu_zero),
    .bit_val_out     (alu_bit)
  );

  // Register read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (paddr_in == REG_ACC_OFS)
    begin
      rd_word[7:0] = q.acc;
    end
    else if (paddr_in == REG_FLAGS_OFS)
    begin
      rd_word[FLAG_C_BIT]     = q.carry;
      rd_word[FLAG_DIGIT_BIT] = q.digit_carry;
      rd_word[FLAG_Z_BIT]     = q.zero;
    end
    else if (paddr_in == REG_STAT_OFS)
    begin
      rd_word[STAT_PH_LSB +: 2] = q.phase;
      rd_word[STAT_SKIP_BIT]    = q.skip_pend;
      rd_word[STAT_NOP_BIT]     = q.skip_now;
    end
    else if (paddr_in == REG_CTRL_OFS)
    begin
      rd_word[CTRL_EN_BIT] = q.enable;
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  always_comb
  begin
    d          = q;
    d.file_we  = 1'b0;
    d.psc_clr  = 1'b0;
    d.done     = 1'b0;
    d.pin_a_s1 = pin_a_in;
    d.pin_a_s2 = q.pin_a_s1;
    d.pin_c_s1 = pin_c_in;
    d.pin_c_s2 = q.pin_c_s1;
    // Read data and error are latched in the setup phase
    if (apb_setup)
    begin
      d.prdata  = pwrite_in ? 32'h0000_0000 : rd_word;
      d.pslverr = !rd_hit;
    end
    // Software writes; the datapath below overrides in the same cycle
    if (apb_wr && (paddr_in == REG_ACC_OFS))
    begin
      d.acc = pwdata_in[7:0];
    end
    if (apb_wr && (paddr_in == REG_FLAGS_OFS))
    begin
      d.carry       = pwdata_in[FLAG_C_BIT];
      d.digit_carry = pwdata_in[FLAG_DIGIT_BIT];
      d.zero        = pwdata_in[FLAG_Z_BIT];
    end
    if (apb_wr && (paddr_in == REG_CTRL_OFS))
    begin
      d.enable = pwdata_in[CTRL_EN_BIT];
    end
    unique case (q.phase)
      PH_FETCH:
      begin
        if (accept)
        begin
          d.phase     = PH_READ;
          d.skip_now  = q.skip_pend;
          d.skip_pend = 1'b0;
          d.op        = q.skip_pend ? OP_NOP : op_code_in;
          d.addr      = op_addr_in;
          d.lit       = op_literal_in;
          d.bsel      = op_bit_in;
          d.dest      = op_dest_in;
        end
      end
      PH_READ:
      begin
        d.phase = PH_CALC;
        if (q.addr == PORT_A_ADDR)
        begin
          d.opnd = q.pin_a_s2;
        end
        else if (q.addr == PORT_C_ADDR)
        begin
          d.opnd = q.pin_c_s2;
        end
        else
        begin
          d.opnd = file_rd_data_in;
        end
      end
      PH_CALC:
      begin
        d.phase = PH_WRITE;
        d.done  = 1'b1;
        if (add_op)
        begin
          d.carry       = alu_carry;
          d.digit_carry = alu_digit;
          d.zero        = alu_zero;
        end
        if (and_op)
        begin
          d.zero = alu_zero;
        end
        if ((add_op || and_op) && !writes_file)
        begin
          d.acc = alu_res;
        end
        if (writes_file)
        begin
          d.file_we    = 1'b1;
          d.file_wdata = alu_res;
          d.psc_clr    = (q.addr == TIMER_ZERO_COUNT_ADDR) && prescaler_to_timer_in;
        end
        if (q.op == OP_SKIP_IF_ONE)
        begin
          d.skip_pend = alu_bit;
        end
        if (q.op == OP_SKIP_IF_ZERO)
        begin
          d.skip_pend = !alu_bit;
        end
      end
      PH_WRITE:
      begin
        d.phase    = PH_FETCH;
        d.skip_now = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      q             <= '0;
      q.acc         <= ACC_RST;
      q.carry       <= FLAG_RST;
      q.digit_carry <= FLAG_RST;
      q.zero        <= FLAG_RST;
      q.enable      <= CTRL_EN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata_out           = q.prdata;
  assign pready_out           = 1'b1;
  assign pslverr_out          = q.pslverr;
  assign skip_out             = q.skip_now;
  assign done_out             = q.done;
  assign file_addr_out        = q.addr;
  assign file_we_out          = q.file_we;
  assign file_wdata_out       = q.file_wdata;
  assign prescaler_clear_out  = q.psc_clr;
  assign acc_out              = q.acc;
  assign carry_out            = q.carry;
  assign digit_carry_flag_out = q.digit_carry;
  assign zero_out             = q.zero;

  // Checks
  logic [8:0] chk_sum;
  logic       in_calc;
  assign chk_sum = {1'b0, q.acc} + {1'b0, alu_opnd};
  assign in_calc = (q.phase == PH_CALC);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  add_lit_acc_a: assert property (
    in_calc && (q.op == OP_ADD_LITERAL) |=> (acc_out == $past(chk_sum[7:0])) && !file_we_out)
    else $error("add literal result wrong");
  add_reg_file_a: assert property (
    in_calc && (q.op == OP_ADD_REGISTER) && q.dest
    |=> file_we_out && (file_wdata_out == $past(chk_sum[7:0])))
    else $error("add register write wrong");
  dest_acc_a: assert property (
    in_calc && reg_op && !q.dest |=> !file_we_out ##1 !file_we_out)
    else $error("destination zero wrote file");
  and_lit_a: assert property (
    in_calc && (q.op == OP_AND_LITERAL)
    |=> (acc_out == $past(q.acc & q.lit)) && $stable(carry_out) && $stable(digit_carry_flag_out))
    else $error("and literal wrong");
  and_reg_a: assert property (
    in_calc && (q.op == OP_AND_REGISTER) && q.dest
    |=> file_we_out && (file_wdata_out == $past(q.acc & q.opnd)) && $stable(carry_out))
    else $error("and register wrong");
  bit_clear_a: assert property (
    in_calc && (q.op == OP_BIT_CLEAR)
    |=> file_we_out && (file_wdata_out == ($past(q.opnd) & ~(8'h01 << $past(q.bsel))))
        && $stable(zero_out))
    else $error("bit clear wrong");
  bit_set_a: assert property (
    in_calc && (q.op == OP_BIT_SET)
    |=> file_we_out && (file_wdata_out == ($past(q.opnd) | (8'h01 << $past(q.bsel))))
        && $stable(carry_out))
    else $error("bit set wrong");
  skip_one_a: assert property (
    in_calc && (q.op == OP_SKIP_IF_ONE)
    |=> (q.skip_pend == $past(q.opnd[q.bsel])))
    else $error("skip if one decision wrong");
  skip_zero_a: assert property (
    in_calc && (q.op == OP_SKIP_IF_ZERO)
    |=> (q.skip_pend == !$past(q.opnd[q.bsel])))
    else $error("skip if zero decision wrong");
  skip_discard_a: assert property (
    q.skip_pend && accept |=> (skip_out && (q.op == OP_NOP) && !file_we_out) [*3])
    else $error("skipped instruction not discarded");
  test_keep_a: assert property (
    in_calc && test_op
    |=> !file_we_out && $stable(carry_out) && $stable(zero_out) && $stable(acc_out))
    else $error("bit test modified state");
  port_pins_a: assert property (
    (q.phase == PH_READ) && (q.addr == PORT_A_ADDR) |=> (q.opnd == $past(q.pin_a_s2)))
    else $error("port read not from pins");
  prescale_a: assert property (
    in_calc && writes_file && (q.addr == TIMER_ZERO_COUNT_ADDR) && prescaler_to_timer_in
    |=> prescaler_clear_out && file_we_out)
    else $error("prescaler not cleared");
  add_flags_a: assert property (
    in_calc && add_op
    |=> (carry_out == $past(chk_sum[8])) && (zero_out == ($past(chk_sum[7:0]) == 8'h00)))
    else $error("add flags wrong");
  one_cycle_a: assert property (
    accept |-> ##3 done_out ##1 (q.phase == PH_FETCH))
    else $error("instruction cycle length wrong");

  skip_taken_c: cover property (in_calc && test_op ##1 q.skip_pend);
  add_carry_c:  cover property (in_calc && add_op ##1 carry_out);
  timer_clr_c:  cover property (prescaler_clear_out);
  port_read_c:  cover property ((q.phase == PH_READ) && (q.addr == PORT_C_ADDR));
endmodule

/* File: verilog/bab_pkg.sv */
package bab_pkg;
  // Datapath widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BSEL_W  = 3;

  // Operations handed over by the decoder
  typedef enum logic [3:0] {
    OP_NOP            = 4'h0,
    OP_ADD_LITERAL    = 4'h1,
    OP_ADD_REGISTER   = 4'h2,
    OP_AND_LITERAL    = 4'h3,
    OP_AND_REGISTER   = 4'h4,
    OP_BIT_CLEAR      = 4'h5,
    OP_BIT_SET        = 4'h6,
    OP_SKIP_IF_ONE    = 4'h7,
    OP_SKIP_IF_ZERO   = 4'h8
  } bab_op_t;

  // Four clock phases per instruction cycle
  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_READ  = 2'b01,
    PH_CALC  = 2'b11,
    PH_WRITE = 2'b10
  } bab_phase_t;

  // APB register map
  localparam int unsigned    APB_AW        = 12;
  localparam logic [11:0]    REG_ACC_OFS   = 12'h000;
  localparam logic [11:0]    REG_FLAGS_OFS = 12'h004;
  localparam logic [11:0]    REG_STAT_OFS  = 12'h008;
  localparam logic [11:0]    REG_CTRL_OFS  = 12'h00c;

  // Field positions
  localparam int unsigned    FLAG_C_BIT     = 0;
  localparam int unsigned    FLAG_DIGIT_BIT = 1;
  localparam int unsigned    FLAG_Z_BIT     = 2;
  localparam int unsigned    STAT_PH_LSB    = 0;
  localparam int unsigned    STAT_SKIP_BIT  = 2;
  localparam int unsigned    STAT_NOP_BIT   = 3;
  localparam int unsigned    CTRL_EN_BIT    = 0;

  // Reset values
  localparam logic [7:0]     ACC_RST        = 8'h00;
  localparam logic           FLAG_RST       = 1'b0;
  localparam logic           CTRL_EN_RST    = 1'b1;

  // File addresses with side effects (plain defaults)
  localparam logic [6:0]     TIMER_ZERO_COUNT_ADDR_DEF = 7'h01;
  localparam logic [6:0]     PORT_A_ADDR_DEF           = 7'h05;
  localparam logic [6:0]     PORT_C_ADDR_DEF           = 7'h07;
endpackage

/* File: verilog/bab_alu.sv */
`timescale 1ns/1ps
module bab_alu (
  input  wire bab_pkg::bab_op_t op_in,
  input  wire logic [7:0]       acc_in,
  input  wire logic [7:0]       opnd_in,
  input  wire logic [2:0]       bsel_in,
  output logic      [7:0]       res_out,
  output logic                  carry_out,
  output logic                  digit_carry_out,
  output logic                  zero_out,
  output logic                  bit_val_out
);
  import bab_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] mask;

  always_comb
  begin
    sum         = {1'b0, acc_in} + {1'b0, opnd_in};
    nib         = {1'b0, acc_in[3:0]} + {1'b0, opnd_in[3:0]};
    mask        = 8'h01 << bsel_in;
    carry_out       = sum[8];
    digit_carry_out = nib[4];
    bit_val_out = opnd_in[bsel_in];
    unique case (op_in)
      OP_ADD_LITERAL, OP_ADD_REGISTER:
        res_out = sum[7:0];
      OP_AND_LITERAL, OP_AND_REGISTER:
        res_out = acc_in & opnd_in;
      OP_BIT_CLEAR:
        res_out = opnd_in & ~mask;
      OP_BIT_SET:
        res_out = opnd_in | mask;
      default:
        res_out = opnd_in;
    endcase
    zero_out = (res_out == 8'h00);
  end
endmodule

/* File: bench/bab_file_model.sv */
`timescale 1ns/1ps
module bab_file_model (
  input  wire logic       clk_in,
  input  wire logic [6:0] addr_in,
  input  wire logic       we_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rd_data_out
);
  logic [7:0] mem [0:127];

  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'h00;
  end

  // Combinational read of the addressed location
  assign rd_data_out = mem[addr_in];

  // Write on the one-cycle strobe
  always @(posedge clk_in)
  begin
    if (we_in)
      mem[addr_in] <= wdata_in;
  end
endmodule

/* File: bench/byte_arith_bit_skip_exec_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %0h exp %0h", $time, (g), (e)); end end
module byte_arith_bit_skip_exec_tb;
  import bab_pkg::*;
  logic clk_in = 1'b0, nrst_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, op_valid = 1'b0, op_dest = 1'b0, op_ready;
  bab_op_t op_code = OP_NOP;
  logic [6:0] op_addr = 7'h00, file_addr;
  logic [7:0] op_lit = 8'h00, rdat, wdat, pin_a = 8'h00, pin_c = 8'h00, acc, ex;
  logic [2:0] op_bit = 3'h0, fl;
  logic skip, done, we, presc = 1'b0, pclr, c, dc, z, skip_seen, clr_seen, we_seen;
  int bad_count = 0, total_checks = 0;

  always #50 clk_in = ~clk_in;

  bab_exec u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .op_valid_in(op_valid),
    .op_code_in(op_code), .op_addr_in(op_addr), .op_literal_in(op_lit),
    .op_bit_in(op_bit), .op_dest_in(op_dest), .op_ready_out(op_ready), .skip_out(skip),
    .done_out(done), .file_addr_out(file_addr), .file_rd_data_in(rdat),
    .file_we_out(we), .file_wdata_out(wdat), .pin_a_in(pin_a), .pin_c_in(pin_c),
    .prescaler_to_timer_in(presc), .prescaler_clear_out(pclr), .acc_out(acc),
    .carry_out(c), .digit_carry_flag_out(dc), .zero_out(z));

  bab_file_model u_file (.clk_in(clk_in), .addr_in(file_addr), .we_in(we),
    .wdata_in(wdat), .rd_data_out(rdat));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic hang(input string what);
    bad_count++;
    $display("Error %0t: no answer to %s", $time, what);
    print_verdict();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      hang("bus");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_in);
  endtask

  task automatic do_op(input bab_op_t code, input logic [6:0] a, input logic [7:0] lit,
                       input logic [2:0] b, input logic d);
    int n;
    @(posedge clk_in);
    op_valid <= 1'b1;
    op_code <= code;
    op_addr <= a;
    op_lit <= lit;
    op_bit <= b;
    op_dest <= d;
    skip_seen = 1'b0;
    clr_seen = 1'b0;
    we_seen = 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (op_ready !== 1'b1 && n < 40);
    if (n >= 40)
      hang("op");
    @(posedge clk_in);
    op_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
      skip_seen |= skip;
      clr_seen |= pclr;
      we_seen |= we;
    end
    while (done !== 1'b1 && n < 10);
    `CHK(n, 3)
    @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic t_regs;
    apb(1'b0, REG_CTRL_OFS, 32'h0);
    `CHK(rd[0], 1'b1)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b1, REG_CTRL_OFS, 32'h0);
    `CHK(op_ready, 1'b0)
    apb(1'b0, REG_STAT_OFS, 32'h0);
    `CHK(rd[3:0], 4'h0)
    apb(1'b1, REG_CTRL_OFS, 32'h1);
    `CHK(op_ready, 1'b1)
    apb(1'b1, REG_FLAGS_OFS, 32'h0);
    apb(1'b1, REG_ACC_OFS, 32'h0f);
    $display("test regs done");
  endtask

  task automatic t_add;
    do_op(OP_ADD_LITERAL, 7'h00, 8'h01, 3'h0, 1'b0);
    `CHK({acc, c, dc, z}, {8'h10, 3'b010})
    do_op(OP_ADD_LITERAL, 7'h00, 8'hf0, 3'h0, 1'b0);
    `CHK({acc, c, dc, z}, {8'h00, 3'b101})
    do_op(OP_ADD_LITERAL, 7'h00, 8'hff, 3'h0, 1'b0);
    `CHK({acc, c, dc, z}, {8'hff, 3'b000})
    u_file.mem[32] = 8'h88;
    do_op(OP_ADD_REGISTER, 7'h20, 8'h00, 3'h0, 1'b0);
    `CHK({acc, c, dc, z, we_seen}, {8'h87, 4'b1100})
    do_op(OP_ADD_REGISTER, 7'h20, 8'h00, 3'h0, 1'b1);
    `CHK({acc, c, dc, z}, {8'h87, 3'b100})
    `CHK(u_file.mem[32], 8'h0f)
    apb(1'b0, REG_ACC_OFS, 32'h0);
    `CHK(rd[7:0], 8'h87)
    apb(1'b0, REG_FLAGS_OFS, 32'h0);
    `CHK(rd[2:0], 3'b001)
    $display("test add done");
  endtask

  task automatic t_and;
    do_op(OP_AND_LITERAL, 7'h00, 8'h78, 3'h0, 1'b0);
    `CHK({acc, c, dc, z}, {8'h00, 3'b101})
    apb(1'b1, REG_ACC_OFS, 32'h3c);
    u_file.mem[33] = 8'h0f;
    do_op(OP_AND_REGISTER, 7'h21, 8'h00, 3'h0, 1'b1);
    `CHK({acc, c, dc, z}, {8'h3c, 3'b100})
    `CHK(u_file.mem[33], 8'h0c)
    $display("test and done");
  endtask

  task automatic t_bits;
    for (int b = 0; b < 8; b++)
    begin
      u_file.mem[34] = 8'h00;
      u_file.mem[35] = 8'hff;
      do_op(OP_BIT_SET, 7'h22, 8'h00, 3'(b), 1'b0);
      `CHK(u_file.mem[34], 8'h01 << b)
      do_op(OP_BIT_CLEAR, 7'h23, 8'h00, 3'(b), 1'b0);
      `CHK(u_file.mem[35], ~(8'h01 << b))
      `CHK({acc, c, dc, z}, {8'h3c, 3'b100})
    end
    $display("test bits done");
  endtask

  task automatic t_skip;
    bab_op_t tops [4] = '{OP_SKIP_IF_ONE, OP_SKIP_IF_ONE, OP_SKIP_IF_ZERO, OP_SKIP_IF_ZERO};
    logic [2:0] tbit [4] = '{3'h7, 3'h1, 3'h1, 3'h0};
    logic texp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    apb(1'b1, REG_ACC_OFS, 32'h0);
    ex = 8'h00;
    u_file.mem[36] = 8'h81;
    for (int i = 0; i < 4; i++)
    begin
      fl = {c, dc, z};
      do_op(tops[i], 7'h24, 8'h00, tbit[i], 1'b1);
      `CHK({acc, c, dc, z, we_seen}, {ex, fl, 1'b0})
      `CHK(u_file.mem[36], 8'h81)
      do_op(OP_ADD_LITERAL, 7'h00, 8'h01, 3'h0, 1'b0);
      if (!texp[i])
        ex = ex + 8'h01;
      `CHK(skip_seen, texp[i])
      `CHK(acc, ex)
    end
    $display("test skip done");
  endtask

  task automatic t_side;
    u_file.mem[5] = 8'hff;
    @(posedge clk_in);
    pin_a <= 8'h0f;
    do_op(OP_BIT_SET, 7'h05, 8'h00, 3'h4, 1'b0);
    `CHK(u_file.mem[5], 8'h1f)
    u_file.mem[7] = 8'h00;
    @(posedge clk_in);
    pin_c <= 8'hf0;
    do_op(OP_BIT_CLEAR, PORT_C_ADDR_DEF, 8'h00, 3'h4, 1'b0);
    `CHK(u_file.mem[7], 8'he0)
    @(posedge clk_in);
    presc <= 1'b1;
    do_op(OP_BIT_SET, 7'h01, 8'h00, 3'h0, 1'b0);
    `CHK(clr_seen, 1'b1)
    @(posedge clk_in);
    presc <= 1'b0;
    do_op(OP_BIT_SET, 7'h01, 8'h00, 3'h1, 1'b0);
    `CHK(clr_seen, 1'b0)
    $display("test side effects done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_add();
    t_and();
    t_bits();
    t_skip();
    t_side();
    print_verdict();
  end
endmodule
